//--- common/adsf_map.svh
/*
  Register offsets, field positions and reset values of the
  per-axis drive and error status block. Assumes byte addresses on a 32-bit
  bus with one aligned word per register.
*/
`ifndef ADSF_MAP_SVH
`define ADSF_MAP_SVH

// register byte offsets
`define ADSF_OFS_CMD   8'h00
`define ADSF_OFS_MAIN  8'h04
`define ADSF_OFS_DRV   8'h08
`define ADSF_OFS_ERR   8'h0c
`define ADSF_OFS_CFG   8'h10
`define ADSF_OFS_UCMP  8'h14
`define ADSF_OFS_LCMP  8'h18

// command word fields
`define ADSF_CMD_CODE_LSB 0
`define ADSF_CMD_AXIS_LSB 8

// drive status fields
`define ADSF_DS_FIN_LSB   8

// error status fields
`define ADSF_ES_SUM_MSB   5

// main status fields
`define ADSF_MS_ERR_LSB   4

// reset values
`define ADSF_CFG_RST  16'h0000
`define ADSF_CMP_RST  32'h0000_0000
`define ADSF_AXIS_RST 2'h0

`endif

//--- common/adsf_pkg.sv
/*
  Types of the per-axis drive and error status block: axis profile flags,
  per-axis configuration, bus access records and commands. Assumes the
  drive generator sits on the same clock.
*/
package adsf_pkg;

  // command codes written to the command register
  typedef enum logic [3:0] {
    ADSF_CMD_NOP   = 4'h0,
    ADSF_CMD_DSTOP = 4'h1,
    ADSF_CMD_ISTOP = 4'h2
  } adsf_cmd_t;

  // profile flags from the drive generator, one set per axis
  typedef struct packed {
    logic driving;
    logic dir_minus;
    logic accel_phase;
    logic const_speed_phase;
    logic decel_phase;
    logic jerk_rising;
    logic jerk_flat;
    logic jerk_falling;
    logic pulses_done;
  } adsf_prof_t;

  // per-axis configuration word, bit 0 first from the right
  typedef struct packed {
    logic [1:0] spare;
    logic       real_sel;
    logic       ext_level;
    logic [3:0] ext_en;
    logic       spare_b;
    logic       limit_immediate;
    logic       alarm_level;
    logic       alarm_en;
    logic       minus_level;
    logic       plus_level;
    logic       soft_minus_en;
    logic       soft_plus_en;
  } adsf_cfg_t;

  // register write committed at the end of a data phase
  typedef struct packed {
    logic        en;
    logic [7:0]  ofs;
    logic [31:0] data;
  } adsf_wr_t;

  // register read taken in the wait cycle of a read
  typedef struct packed {
    logic       en;
    logic [7:0] ofs;
  } adsf_rd_t;

endpackage

//--- logic/adsf_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes inputs are asynchronous levels held much longer than a clock.
*/
`timescale 1ns/1ns
module adsf_sync
  import adsf_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- logic/adsf_ahb.sv
/*
  AHB-Lite slave front end: writes commit at the end of a zero-wait data
  phase, reads insert one wait cycle and return registered data.
  Assumes a single master, word transfers only, response always OKAY.
*/
`timescale 1ns/1ns
module adsf_ahb
  import adsf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output adsf_wr_t         wr,
  output adsf_rd_t         rd,
  input  wire logic [31:0] rd_data
);

  logic       take;
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] ofs_q;

  // nonseq or seq address phase accepted
  assign take = hsel & htrans[1] & hready;

  // address phase capture
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ofs_q     <= 8'h00;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take)
        ofs_q <= haddr[7:0];
    end
  end

  // read data loaded in the wait cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      hrdata <= 32'h0000_0000;
    else if (rd_pend_q)
      hrdata <= rd_data;
  end

  // handshake and access records
  assign hreadyout = ~rd_pend_q;
  assign hresp     = 1'b0;
  assign wr        = '{en: wr_pend_q, ofs: ofs_q, data: hwdata};
  assign rd        = '{en: rd_pend_q, ofs: ofs_q};

  // hsize is accepted but only words are meaningful
  logic unused_size;
  assign unused_size = ^hsize;

endmodule

//--- logic/adsf_top.sv
/*
  Four-axis drive status and error status: compare results, profile phases,
  latched drive-finish causes, error levels, stop requests and main status,
  reached over AHB-Lite. Assumes the drive generator on sys_clk supplies the
  profile flags and position counters and obeys the stop request outputs.
*/
// Functional notes
// - each axis has own status registers; a no-op command picks which is read
// - bit 0 counter at or above upper compare, bit 1 at or below lower
// - bits 2,3,4 show accelerating, constant speed, decelerating
// - bits 5,6,7 show S-curve acceleration rising, flat, falling
// - finish cause bits keep the last drive termination cause after the drive
// - a fixed-pulse drive ends once all its pulses are out
// - decelerating or immediate stop command ends any drive
// - enabled software limit becoming true ends the drive
// - enabled external decel input stops drive and sets its bit 11..8
// - plus or minus limit switch stopping the drive sets bit 12 or 13
// - enabled servo alarm stops drive and sets bit 14
// - emergency input low stops drive and sets bit 15
// - each error bit reads 1 exactly while its condition exists
// - main status error bit of an axis is the OR of error bits 5..0
// - error bit 1: minus drive at or below enabled lower soft limit
// - error bit 2 follows plus limit switch at its active level
// - an active soft limit, or a hard limit toward the drive, while driving stops decel or immediate
// - soft limit bits never set while driving away from that limit
`timescale 1ns/1ns
`include "adsf_map.svh"
module adsf_top
  import adsf_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  input  wire adsf_prof_t         prof        [4],
  input  wire logic signed [31:0] logical_pos [4],
  input  wire logic signed [31:0] real_pos    [4],
  input  wire logic [3:0]         plus_limit_input,
  input  wire logic [3:0]         minus_limit_input,
  input  wire logic [3:0]         servo_alarm_input,
  input  wire logic [15:0]        ext_decel_input,
  input  wire logic               emergency_input_n,
  output logic      [3:0]         stop_decel,
  output logic      [3:0]         stop_immediate
);

  adsf_wr_t     wr;
  adsf_rd_t     rd;
  logic [31:0]  rd_data;
  logic [28:0]  pin_raw;
  logic [28:0]  pin_sync;
  logic [1:0]   sel_q;
  adsf_cfg_t    cfg_q   [4];
  logic [31:0]  ucmp_q  [4];
  logic [31:0]  lcmp_q  [4];
  logic [3:0]   cmd_dstop_q;
  logic [3:0]   cmd_istop_q;
  logic [7:0]   fin_q   [4];
  logic [3:0]   drv_prev_q;
  logic [15:0]  drv_stat [4];
  logic [15:0]  err_stat [4];
  logic [3:0]   err_any;
  logic [3:0]   driving;
  logic [15:0]  main_stat;
  adsf_cmd_t    cmd_code;
  logic [1:0]   cmd_axis;

  // signed at-or-above test, shared by both compare registers
  function automatic logic at_or_above(input logic signed [31:0] a,
                                       input logic signed [31:0] b);
    at_or_above = (a >= b);
  endfunction

  // bus front end
  adsf_ahb u_ahb (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr        (wr),
    .rd        (rd),
    .rd_data   (rd_data)
  );

  // pins enter through two flops; emergency is carried active high
  assign pin_raw = {~emergency_input_n, ext_decel_input, servo_alarm_input,
                    minus_limit_input, plus_limit_input};

  adsf_sync #(.W(29)) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  // command word decode
  assign cmd_code = adsf_cmd_t'(wr.data[`ADSF_CMD_CODE_LSB +: 4]);
  assign cmd_axis = wr.data[`ADSF_CMD_AXIS_LSB +: 2];

  // axis select: only the no-op command moves it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sel_q <= `ADSF_AXIS_RST;
    else if (wr.en && wr.ofs == `ADSF_OFS_CMD && cmd_code == ADSF_CMD_NOP)
      sel_q <= cmd_axis;
  end

  // one-cycle stop command strobes per axis
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cmd_dstop_q <= 4'h0;
      cmd_istop_q <= 4'h0;
    end
    else
    begin
      cmd_dstop_q <= 4'h0;
      cmd_istop_q <= 4'h0;
      if (wr.en && wr.ofs == `ADSF_OFS_CMD)
      begin
        cmd_dstop_q[cmd_axis] <= (cmd_code == ADSF_CMD_DSTOP);
        cmd_istop_q[cmd_axis] <= (cmd_code == ADSF_CMD_ISTOP);
      end
    end
  end

  // per-axis configuration and compare registers of the selected axis
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
      begin
        cfg_q[i]  <= adsf_cfg_t'(`ADSF_CFG_RST);
        ucmp_q[i] <= `ADSF_CMP_RST;
        lcmp_q[i] <= `ADSF_CMP_RST;
      end
    end
    else if (wr.en)
    begin
      unique case (wr.ofs)
        `ADSF_OFS_CFG:  cfg_q[sel_q]  <= adsf_cfg_t'(wr.data[15:0]);
        `ADSF_OFS_UCMP: ucmp_q[sel_q] <= wr.data;
        `ADSF_OFS_LCMP: lcmp_q[sel_q] <= wr.data;
        default:        ;
      endcase
    end
  end

  for (genvar a = 0; a < 4; a++)
  begin : g_axis
    logic signed [31:0] pos;
    logic       ge_upper;
    logic       le_lower;
    logic       plus_pin;
    logic       minus_pin;
    logic       alarm_pin;
    logic       emerg;
    logic [3:0] ext_pin;
    logic       soft_plus;
    logic       soft_minus;
    logic       hard_plus;
    logic       hard_minus;
    logic       alarm_act;
    logic [3:0] ext_act;
    logic       c_plim;
    logic       c_mlim;
    logic       c_alarm;
    logic       c_soft;
    logic       c_limit;
    logic       imm;
    logic       dec;
    logic       start;
    logic [7:0] causes;
    adsf_prof_t p;

    assign p         = prof[a];
    assign plus_pin  = pin_sync[a];
    assign minus_pin = pin_sync[4 + a];
    assign alarm_pin = pin_sync[8 + a];
    assign ext_pin   = pin_sync[12 + 4*a +: 4];
    assign emerg     = pin_sync[28];

    // compare against the chosen counter
    assign pos      = cfg_q[a].real_sel ? real_pos[a] : logical_pos[a];
    assign ge_upper = at_or_above(pos, ucmp_q[a]);
    assign le_lower = at_or_above(lcmp_q[a], pos);

    // error conditions, live levels
    assign soft_plus  = cfg_q[a].soft_plus_en & p.driving & ~p.dir_minus
                        & ge_upper;
    assign soft_minus = cfg_q[a].soft_minus_en & p.driving & p.dir_minus
                        & le_lower;
    assign hard_plus  = (plus_pin == cfg_q[a].plus_level);
    assign hard_minus = (minus_pin == cfg_q[a].minus_level);
    assign alarm_act  = (alarm_pin == cfg_q[a].alarm_level);
    assign ext_act    = cfg_q[a].ext_en & (cfg_q[a].ext_level ? ext_pin : ~ext_pin);

    // error status word
    assign err_stat[a] = {10'h000, emerg, alarm_act, hard_minus, hard_plus,
                          soft_minus, soft_plus};
    assign err_any[a]  = |err_stat[a][`ADSF_ES_SUM_MSB:0];

    // stop causes while driving; a switch stops only the drive toward it
    assign c_plim  = hard_plus & ~p.dir_minus;
    assign c_mlim  = hard_minus & p.dir_minus;
    assign c_alarm = cfg_q[a].alarm_en & alarm_act;
    assign c_soft  = soft_plus | soft_minus;
    assign c_limit = c_plim | c_mlim | c_soft;
    assign imm = p.driving & (emerg | c_alarm | cmd_istop_q[a] | p.pulses_done
                 | (cfg_q[a].limit_immediate & c_limit));
    assign dec = p.driving & (|ext_act | cmd_dstop_q[a]
                 | (~cfg_q[a].limit_immediate & c_limit));

    // stop requests to the drive generator
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        stop_immediate[a] <= 1'b0;
        stop_decel[a]     <= 1'b0;
      end
      else
      begin
        stop_immediate[a] <= imm;
        stop_decel[a]     <= dec & ~imm;
      end
    end

    // finish causes: cleared at drive start, a cause in that cycle still lands
    assign start  = p.driving & ~drv_prev_q[a];
    assign causes = p.driving ? {emerg, c_alarm, c_mlim, c_plim, ext_act} : 8'h00;

    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        fin_q[a]      <= 8'h00;
        drv_prev_q[a] <= 1'b0;
      end
      else
      begin
        fin_q[a]      <= (start ? 8'h00 : fin_q[a]) | causes;
        drv_prev_q[a] <= p.driving;
      end
    end

    // drive status word; phase bits only while driving
    assign drv_stat[a] = {fin_q[a],
                          {p.jerk_falling, p.jerk_flat, p.jerk_rising} & {3{p.driving}},
                          {p.decel_phase, p.const_speed_phase, p.accel_phase}
                            & {3{p.driving}},
                          le_lower, ge_upper};

    assign driving[a] = p.driving;
  end

  // main status: drive flags and error summaries
  assign main_stat = {8'h00, err_any, driving};

  // read mux, the selected axis copy for per-axis registers
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (rd.en)
    begin
      unique case (rd.ofs)
        `ADSF_OFS_CMD:  rd_data = {22'h000000, sel_q, 8'h00};
        `ADSF_OFS_MAIN: rd_data = {16'h0000, main_stat};
        `ADSF_OFS_DRV:  rd_data = {16'h0000, drv_stat[sel_q]};
        `ADSF_OFS_ERR:  rd_data = {16'h0000, err_stat[sel_q]};
        `ADSF_OFS_CFG:  rd_data = {16'h0000, cfg_q[sel_q]};
        `ADSF_OFS_UCMP: rd_data = ucmp_q[sel_q];
        `ADSF_OFS_LCMP: rd_data = lcmp_q[sel_q];
        default:        rd_data = 32'h0000_0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence nop_write_s;
    wr.en && wr.ofs == `ADSF_OFS_CMD && cmd_code == ADSF_CMD_NOP;
  endsequence

  axis_select_a: assert property (nop_write_s |=> sel_q == $past(cmd_axis))
    else $error("axis select did not follow no-op command");

  read_select_a: assert property (rd.en && rd.ofs == `ADSF_OFS_ERR
                                  |=> hrdata[15:0] == $past(err_stat[sel_q]))
    else $error("error read not from selected axis");

  for (genvar a = 0; a < 4; a++)
  begin : g_chk
    sequence istop_cmd_s;
      wr.en && wr.ofs == `ADSF_OFS_CMD && cmd_code == ADSF_CMD_ISTOP
        && cmd_axis == a;
    endsequence

    upper_cmp_a: assert property (drv_stat[a][0]
      == (g_axis[a].pos >= $signed(ucmp_q[a])))
      else $error("upper compare bit wrong");

    phase_idle_a: assert property (!prof[a].driving |-> drv_stat[a][7:2] == 6'h00)
      else $error("phase bits set while idle");

    finish_hold_a: assert property (!prof[a].driving && !drv_prev_q[a]
                                    |=> fin_q[a] == $past(fin_q[a]))
      else $error("finish causes changed while idle");

    pulse_done_a: assert property (prof[a].driving && prof[a].pulses_done
                                   |=> stop_immediate[a])
      else $error("no stop after last pulse");

    cmd_stop_a: assert property (istop_cmd_s ##1 prof[a].driving
                                 |=> stop_immediate[a])
      else $error("immediate stop command ignored");

    soft_stop_a: assert property (g_axis[a].c_soft
                                  |=> stop_immediate[a] || stop_decel[a])
      else $error("soft limit did not stop drive");

    ext_flag_a: assert property (prof[a].driving && g_axis[a].ext_act[0]
                                 |=> fin_q[a][0] && (stop_decel[a] || stop_immediate[a]))
      else $error("external decel stop not flagged");

    plus_flag_a: assert property (prof[a].driving && g_axis[a].c_plim
                                  |=> fin_q[a][4])
      else $error("plus switch stop not flagged");

    alarm_flag_a: assert property (prof[a].driving && g_axis[a].c_alarm
                                   |=> fin_q[a][6] && stop_immediate[a])
      else $error("alarm stop not flagged");

    emg_flag_a: assert property (prof[a].driving && pin_sync[28]
                                 |=> fin_q[a][7] && stop_immediate[a])
      else $error("emergency stop not flagged");

    err_sum_a: assert property ($rose(err_any[a]) |-> main_stat[4 + a])
      else $error("main error bit missing");

    soft_dir_a: assert property (prof[a].dir_minus |-> !err_stat[a][0])
      else $error("plus soft limit set in minus drive");

    hard_plus_a: assert property (err_stat[a][2]
                                  == (pin_sync[a] == cfg_q[a].plus_level))
      else $error("plus switch error bit wrong");
  end

endmodule

//--- dv/adsf_gen_model.sv
/*
  Drive generator model: per-axis drive state, profile flags and position.
  Assumes start and load pulses from the bench on sys_clk and obeys the
  stop request outputs of the status block.
*/
`timescale 1ns/1ns
module adsf_gen_model
  import adsf_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [3:0]         start,
  input  wire logic               start_minus,
  input  wire logic [15:0]        npulses,
  input  wire logic [3:0]         pos_set,
  input  wire logic signed [31:0] pos_val,
  input  wire logic [3:0]         stop_decel,
  input  wire logic [3:0]         stop_immediate,
  output adsf_prof_t              prof        [4],
  output logic signed [31:0]      logical_pos [4],
  output logic signed [31:0]      real_pos    [4]
);
  logic [3:0]  drv_q;
  logic [3:0]  minus_q;
  logic [3:0]  slow_q;
  logic [15:0] cnt_q  [4];
  logic [2:0]  age_q  [4];
  logic [1:0]  tail_q [4];

  // drive state per axis; a decel stop runs a short tail first
  always_ff @(posedge sys_clk)
  begin
    for (int a = 0; a < 4; a++)
    begin
      if (reset)
      begin
        drv_q[a]       <= 1'b0;
        slow_q[a]      <= 1'b0;
        logical_pos[a] <= 32'sh0;
      end
      else if (!drv_q[a])
      begin
        drv_q[a]   <= start[a];
        minus_q[a] <= start_minus;
        slow_q[a]  <= 1'b0;
        cnt_q[a]   <= npulses;
        age_q[a]   <= 3'h0;
        if (pos_set[a])
          logical_pos[a] <= pos_val;
      end
      else
      begin
        logical_pos[a] <= minus_q[a] ? logical_pos[a] - 32'sh1 : logical_pos[a] + 32'sh1;
        cnt_q[a] <= cnt_q[a] - 16'h1;
        if (age_q[a] != 3'h7)
          age_q[a] <= age_q[a] + 3'h1;
        if (stop_immediate[a] || (slow_q[a] && tail_q[a] == 2'h0))
          drv_q[a] <= 1'b0;
        if (stop_decel[a] && !slow_q[a])
        begin
          slow_q[a] <= 1'b1;
          tail_q[a] <= 2'h2;
        end
        else if (slow_q[a])
          tail_q[a] <= tail_q[a] - 2'h1;
      end
    end
  end

  // profile flags from drive age; last pulse flagged while count is one
  always_comb
  begin
    for (int a = 0; a < 4; a++)
    begin
      prof[a].driving           = drv_q[a];
      prof[a].dir_minus         = minus_q[a];
      prof[a].accel_phase       = drv_q[a] && !slow_q[a] && age_q[a] < 3'h4;
      prof[a].const_speed_phase = drv_q[a] && !slow_q[a] && age_q[a] >= 3'h4;
      prof[a].decel_phase       = drv_q[a] && slow_q[a];
      prof[a].jerk_rising       = prof[a].accel_phase && age_q[a] < 3'h2;
      prof[a].jerk_flat         = prof[a].accel_phase && age_q[a] == 3'h2;
      prof[a].jerk_falling      = prof[a].accel_phase && age_q[a] == 3'h3;
      prof[a].pulses_done       = drv_q[a] && cnt_q[a] == 16'h1;
      real_pos[a]               = logical_pos[a];
    end
  end
endmodule

//--- dv/axis_drive_status_error_flags_tb.sv
/*
  Self-checking bench of the drive and error status block on axis 0.
  Assumes the generator model on the far side and one AHB-Lite master here.
*/
`timescale 1ns/1ns
module axis_drive_status_error_flags_tb;
  import adsf_pkg::*;
  logic                sys_clk = 1'b0;
  logic                reset = 1'b1;
  logic                hsel = 1'b0;
  logic                hwrite = 1'b0;
  logic [31:0]         haddr = 32'h0;
  logic [31:0]         hwdata = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic [2:0]          hsize = 3'h2;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  adsf_prof_t          prof [4];
  logic signed [31:0]  logical_pos [4];
  logic signed [31:0]  real_pos [4];
  logic [3:0]          plus_pin = 4'h0;
  logic [3:0]          minus_pin = 4'h0;
  logic [3:0]          alarm_pin = 4'h0;
  logic [15:0]         ext_pin = 16'h0;
  logic                emg_n = 1'b1;
  logic [3:0]          start = 4'h0;
  logic                start_minus = 1'b0;
  logic [15:0]         npulses = 16'h0;
  logic [3:0]          pos_set = 4'h0;
  logic signed [31:0]  pos_val = 32'sh0;
  logic [3:0]          stop_decel;
  logic [3:0]          stop_immediate;
  int                  errors = 0;
  int                  samples_checked = 0;
  localparam logic [31:0] DRV_E [5] = '{32'h1000, 32'h2000, 32'h4000, 32'h0100, 32'h8000};
  localparam logic [31:0] ERR_E [5] = '{32'h04, 32'h08, 32'h10, 32'h00, 32'h20};
  // axes 2 and 3 keep low active levels and axis 1 a low minus level, so their idle switches read as errors
  localparam logic [31:0] MAIN_E [5] = '{32'hf0, 32'hf0, 32'hf0, 32'he0, 32'hf0};

  // clock of 50 ns period
  always #25 sys_clk = ~sys_clk;

  adsf_top u_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prof(prof),
    .logical_pos(logical_pos), .real_pos(real_pos), .plus_limit_input(plus_pin),
    .minus_limit_input(minus_pin), .servo_alarm_input(alarm_pin),
    .ext_decel_input(ext_pin), .emergency_input_n(emg_n), .stop_decel(stop_decel),
    .stop_immediate(stop_immediate));

  adsf_gen_model u_gen (.sys_clk(sys_clk), .reset(reset), .start(start),
    .start_minus(start_minus), .npulses(npulses), .pos_set(pos_set), .pos_val(pos_val),
    .stop_decel(stop_decel), .stop_immediate(stop_immediate), .prof(prof),
    .logical_pos(logical_pos), .real_pos(real_pos));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer; holds each phase until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, ofs, d, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, ofs, 32'h0, d);
    chk(what, exp, d);
  endtask

  task automatic go(input logic m, input logic [15:0] n);
    start <= 4'h1;
    start_minus <= m;
    npulses <= n;
    @(posedge sys_clk);
    start <= 4'h0;
    @(posedge sys_clk); // drive flag visible on return
  endtask

  task automatic load(input logic signed [31:0] p);
    pos_val <= p;
    pos_set <= 4'h1;
    @(posedge sys_clk);
    pos_set <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (prof[0].driving !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("drive ended", 32'h0, {31'h0, prof[0].driving});
  endtask

  // cause pins of axis 0 and the shared emergency line
  task automatic set_pin(input int k, input logic v);
    case (k)
      0: plus_pin[0] <= v;
      1: minus_pin[0] <= v;
      2: alarm_pin[0] <= v;
      3: ext_pin[0] <= v;
      default: emg_n <= !v;
    endcase
  endtask

  task automatic t_regs();
    rd_chk("selected axis", 8'h00, 32'h0);
    rd_chk("equal compares", 8'h08, 32'h3);
    wr(8'h08, 32'hffff);
    rd_chk("read only", 8'h08, 32'h3);
    wr(8'h1c, 32'hffff_ffff);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(8'h00, 32'h100);
    wr(8'h10, 32'h1234);
    wr(8'h00, 32'h000);
    rd_chk("axis 0 config", 8'h10, 32'h0);
    wr(8'h00, 32'h100);
    rd_chk("axis 1 config", 8'h10, 32'h1234);
    rd_chk("selected axis", 8'h00, 32'h100);
    wr(8'h00, 32'h000);
    $display("test registers done");
  endtask

  task automatic t_compare();
    wr(8'h14, 32'd100);
    wr(8'h18, 32'hffff_ff9c);
    load(32'sd100);
    rd_chk("at upper", 8'h08, 32'h1);
    load(-32'sd101);
    rd_chk("below lower", 8'h08, 32'h2);
    load(32'sd99);
    rd_chk("between", 8'h08, 32'h0);
    wr(8'h14, 32'h7fff_ffff);
    wr(8'h18, 32'h8000_0000);
    wr(8'h10, 32'h117c);
    $display("test compare done");
  endtask

  task automatic t_phase();
    go(1'b0, 16'h0);
    repeat (8) @(posedge sys_clk);
    rd_chk("const phase", 8'h08, 32'h8);
    rd_chk("main driving", 8'h04, 32'he1);
    wr(8'h00, 32'h001);
    wait_idle();
    rd_chk("no finish cause", 8'h08, 32'h0);
    go(1'b0, 16'd6);
    wait_idle();
    $display("test phases done");
  endtask

  task automatic t_causes();
    for (int k = 0; k < 5; k++)
    begin
      go(k == 1, 16'h0);
      repeat (6) @(posedge sys_clk);
      set_pin(k, 1'b1);
      @(posedge sys_clk);
      wait_idle();
      rd_chk("stop cause", 8'h08, DRV_E[k]);
      rd_chk("error bits", 8'h0c, ERR_E[k]);
      rd_chk("main error", 8'h04, MAIN_E[k]);
      set_pin(k, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd_chk("cause kept", 8'h08, DRV_E[k]);
      rd_chk("error gone", 8'h0c, 32'h0);
    end
    $display("test stop causes done");
  endtask

  task automatic t_soft();
    load(32'sd0);
    wr(8'h10, 32'h117d);
    wr(8'h14, 32'hffff_fffb);
    go(1'b1, 16'h0);
    repeat (6) @(posedge sys_clk);
    rd_chk("soft plus reverse", 8'h0c, 32'h0);
    rd_chk("still driving", 8'h04, 32'he1);
    wr(8'h00, 32'h002);
    wait_idle();
    go(1'b0, 16'h0);
    wait_idle();
    rd_chk("past upper", 8'h08, 32'h1);
    wr(8'h14, 32'h7fff_ffff);
    wr(8'h18, 32'hffff_fffd);
    wr(8'h10, 32'h313e); // decel on limit, real counter
    load(32'sd0);
    go(1'b1, 16'h0);
    wait_idle();
    rd_chk("past lower", 8'h08, 32'h2);
    $display("test soft limits done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence after three reset cycles
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_compare();
    t_phase();
    t_causes();
    t_soft();
    summarize();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule
